// *** mei_pkg.sv ***
// What this block does
// - Clear bit write releases all latched interrupts
// - Drive field: zero push-pull, one open-drain
// - Polarity field: zero active high, one low
// - Codes 0/8 follow event; 7/15 latch
// - Codes 1-6 hold 250ms to 8s
// - Codes 9-14 hold 1ms to 100ms
// - Free fall persists (setting+1)*2ms before firing
// - Free-fall threshold is setting times 7.81mg
// - Fall mode: per-axis or summed magnitude
// - Free-fall hysteresis is setting times 125mg
// - Inactivity needs (upper nibble+1) evaluation periods
// - Activity needs (lower nibble+1) evaluation periods
// - Activity step is a fixed raw count at every full-scale range
// - Quiet bit: 30ms or 20ms
// - Shock bit: 50ms or 70ms
// - Window code picks second-knock wait time
// - Knock step is a fixed raw count at every full-scale range
// - Event reaches pin only when routed
// - Oversampled source evaluates eight times per output
// - Each event sets a readable status flag
package mei_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS         = 1000000;
   localparam int TICK_CYCLES   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [5:0] IDX_PIN_CFG    = 6'h20;
   localparam logic [5:0] IDX_HOLD       = 6'h21;
   localparam logic [5:0] IDX_FALL_DLY   = 6'h22;
   localparam logic [5:0] IDX_FALL_TH    = 6'h23;
   localparam logic [5:0] IDX_FALL_HYST  = 6'h24;
   localparam logic [5:0] IDX_MOT_DUR    = 6'h27;
   localparam logic [5:0] IDX_MOT_TH     = 6'h28;
   localparam logic [5:0] IDX_KNOCK_TIME = 6'h2A;
   localparam logic [5:0] IDX_KNOCK_TH   = 6'h2B;
   localparam logic [5:0] IDX_ROUTE      = 6'h30;
   localparam logic [5:0] IDX_STATUS     = 6'h31;
   localparam logic [5:0] IDX_SENSE      = 6'h32;

   localparam logic [7:0] RST_PIN_CFG    = 8'h00;
   localparam logic [7:0] RST_HOLD       = 8'h00;
   localparam logic [7:0] RST_FALL_DLY   = 8'h09;
   localparam logic [7:0] RST_FALL_TH    = 8'h30;
   localparam logic [7:0] RST_FALL_HYST  = 8'h01;
   localparam logic [7:0] RST_MOT_DUR    = 8'h00;
   localparam logic [7:0] RST_MOT_TH     = 8'h14;
   localparam logic [7:0] RST_KNOCK_TIME = 8'h04;
   localparam logic [7:0] RST_KNOCK_TH   = 8'h0A;
   localparam logic [7:0] RST_ROUTE      = 8'h00;
   localparam logic [7:0] RST_SENSE      = 8'h00;

   localparam int CFG_CLEAR_BIT   = 7;
   localparam int CFG_OD_BIT      = 1;
   localparam int CFG_POL_BIT     = 0;
   localparam int FALL_MODE_BIT   = 2;
   localparam int KNOCK_QUIET_BIT = 7;
   localparam int KNOCK_SHOCK_BIT = 6;
   localparam int EVT_SINGLE      = 5;
   localparam int EVT_DOUBLE      = 4;
   localparam int EVT_ACTIVE      = 2;
   localparam int EVT_FALL        = 0;
   localparam logic [7:0] EVT_MASK = 8'h35;

   localparam logic [3:0] HOLD_NONE_A  = 4'h0;
   localparam logic [3:0] HOLD_LATCH_A = 4'h7;
   localparam logic [3:0] HOLD_NONE_B  = 4'h8;
   localparam logic [3:0] HOLD_LATCH_B = 4'hF;
   localparam logic [13:0] HOLD_MS [16] = '{14'h0000, 14'h00FA, 14'h01F4, 14'h03E8, 14'h07D0, 14'h0FA0,
                                            14'h1F40, 14'h0000, 14'h0000, 14'h0001, 14'h0001, 14'h0002,
                                            14'h0019, 14'h0032, 14'h0064, 14'h0000};

   localparam logic [9:0] FALL_STEP_MS = 10'h002;
   localparam logic [9:0] QUIET_MS_0   = 10'h01E;
   localparam logic [9:0] QUIET_MS_1   = 10'h014;
   localparam logic [9:0] SHOCK_MS_0   = 10'h032;
   localparam logic [9:0] SHOCK_MS_1   = 10'h046;
   localparam logic [9:0] WINDOW_MS [8] = '{10'h032, 10'h064, 10'h096, 10'h0C8,
                                           10'h0FA, 10'h177, 10'h1F4, 10'h2BC};

   // Steps in raw counts: 4096 counts per g at the 2g range, halving per range step
   localparam logic [3:0] MOT_STEP_SHIFT     = 4'h4;
   localparam logic [3:0] KNOCK_STEP_SHIFT   = 4'h8;
   localparam logic [3:0] FALL_STEP_SHIFT_2G = 4'h5;
   localparam logic [3:0] HYST_STEP_SHIFT_2G = 4'h9;
   localparam logic [1:0] FS_8G              = 2'h2;
   localparam logic [1:0] SRC_OVERSAMPLED    = 2'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {KNOCK_IDLE, KNOCK_SHOCK, KNOCK_QUIET, KNOCK_WAIT2, KNOCK_SHOCK2} mei_knock_t;
endpackage

// *** mei_top.sv ***
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module mei_top
   import mei_pkg::*;
#(
   parameter int MS_CYCLES = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready,
   // Acceleration samples
   input  wire logic [13:0] accel_x,
   input  wire logic [13:0] accel_y,
   input  wire logic [13:0] accel_z,
   input  wire logic        sample_os_stb,
   input  wire logic        sample_odr_stb,
   // Interrupt pin
   output var  logic        event_pin_out,
   output var  logic        event_pin_oe_n
);
   logic [7:0]  pin_cfg_r, hold_mode_r, fall_dly_r, fall_th_r, fall_hyst_r;
   logic [7:0]  mot_dur_r, mot_th_r, knock_time_r, knock_th_r, route_r, status_r, sense_r;
   logic        wr_en, wr_lo, clear_strobe, ms_tick, eval_stb;
   logic [5:0]  wr_idx;
   logic [7:0]  rd_val, evt_vec, status_clr;
   logic [15:0] tick_cnt_r;
   logic [13:0] mx, my, mz, hold_cnt_r;
   logic [15:0] msum, fall_th_lsb, fall_exit_lsb, mot_th_lsb, knock_th_lsb;
   logic [3:0]  hold_code, fall_sh, hyst_sh;
   logic [1:0]  fs_sel;
   logic        hold_none, hold_latch, mapped_evt, held_r, pin_od, pin_pol;
   logic        fall_below, fall_exit, fall_cond_r, fall_fired_r, fall_evt;
   logic [9:0]  fall_cnt_r, fall_target;
   logic        mot_over, active_r, act_evt;
   logic [4:0]  act_cnt_r, inact_cnt_r;
   logic        knock_over, single_evt, double_evt;
   logic [9:0]  knock_ms_r, shock_ms, quiet_ms, window_ms;
   mei_knock_t  knock_state_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   function automatic logic idx_mapped(input logic [5:0] idx);
      return idx inside {IDX_PIN_CFG, IDX_HOLD, IDX_FALL_DLY, IDX_FALL_TH, IDX_FALL_HYST, IDX_MOT_DUR,
                         IDX_MOT_TH, IDX_KNOCK_TIME, IDX_KNOCK_TH, IDX_ROUTE, IDX_STATUS, IDX_SENSE};
   endfunction

   function automatic logic [13:0] mag(input logic [13:0] v);
      return v[13] ? 14'(-v) : v;
   endfunction

   // Write channel: address and data are accepted together, one write in flight
   assign wr_en  = awready && awvalid && wready && wvalid;
   assign wr_idx = awaddr[7:2];
   assign wr_lo  = wr_en && wstrb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
      end else begin
         if (awready) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (awvalid && wvalid && !bvalid) begin
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      unique case (araddr[7:2])
         IDX_PIN_CFG:    rd_val = {6'h00, pin_od, pin_pol};
         IDX_HOLD:       rd_val = hold_mode_r;
         IDX_FALL_DLY:   rd_val = fall_dly_r;
         IDX_FALL_TH:    rd_val = fall_th_r;
         IDX_FALL_HYST:  rd_val = fall_hyst_r;
         IDX_MOT_DUR:    rd_val = mot_dur_r;
         IDX_MOT_TH:     rd_val = mot_th_r;
         IDX_KNOCK_TIME: rd_val = knock_time_r;
         IDX_KNOCK_TH:   rd_val = knock_th_r;
         IDX_ROUTE:      rd_val = route_r;
         IDX_STATUS:     rd_val = status_r;
         IDX_SENSE:      rd_val = sense_r;
         default:        rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else begin
         if (arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_val};
            rresp   <= idx_mapped(araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
         end else if (arvalid && !rvalid) begin
            arready <= 1'b1;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Configuration registers; the clear bit is never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_cfg_r    <= RST_PIN_CFG;
         hold_mode_r  <= RST_HOLD;
         fall_dly_r   <= RST_FALL_DLY;
         fall_th_r    <= RST_FALL_TH;
         fall_hyst_r  <= RST_FALL_HYST;
         mot_dur_r    <= RST_MOT_DUR;
         mot_th_r     <= RST_MOT_TH;
         knock_time_r <= RST_KNOCK_TIME;
         knock_th_r   <= RST_KNOCK_TH;
         route_r      <= RST_ROUTE;
         sense_r      <= RST_SENSE;
      end else if (wr_lo) begin
         unique case (wr_idx)
            IDX_PIN_CFG:    pin_cfg_r    <= {6'h00, wdata[CFG_OD_BIT], wdata[CFG_POL_BIT]};
            IDX_HOLD:       hold_mode_r  <= {4'h0, wdata[3:0]};
            IDX_FALL_DLY:   fall_dly_r   <= wdata[7:0];
            IDX_FALL_TH:    fall_th_r    <= wdata[7:0];
            IDX_FALL_HYST:  fall_hyst_r  <= {5'h00, wdata[2:0]};
            IDX_MOT_DUR:    mot_dur_r    <= wdata[7:0];
            IDX_MOT_TH:     mot_th_r     <= wdata[7:0];
            IDX_KNOCK_TIME: knock_time_r <= {wdata[7:6], 3'h0, wdata[2:0]};
            IDX_KNOCK_TH:   knock_th_r   <= {3'h0, wdata[4:0]};
            IDX_ROUTE:      route_r      <= wdata[7:0] & EVT_MASK;
            IDX_SENSE:      sense_r      <= {2'h0, wdata[5:4], 2'h0, wdata[1:0]};
            default:        ;
         endcase
      end
   end

   assign pin_od       = pin_cfg_r[CFG_OD_BIT];
   assign pin_pol      = pin_cfg_r[CFG_POL_BIT];
   assign clear_strobe = wr_lo && (wr_idx == IDX_PIN_CFG) && wdata[CFG_CLEAR_BIT];

   // Status flags: an event in the same cycle as its clear keeps the flag set
   assign status_clr = (wr_lo && wr_idx == IDX_STATUS) ? (wdata[7:0] & EVT_MASK) : 8'h00;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= 8'h00;
      end else begin
         status_r <= (status_r & ~status_clr) | evt_vec;
      end
   end

   // Millisecond time base for every hold, delay and knock window
   always_ff @(posedge aclk) begin
      if (!aresetn || ms_tick) begin
         tick_cnt_r <= 16'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end
   assign ms_tick = (tick_cnt_r == 16'(MS_CYCLES - 1));

   // Sample magnitudes and thresholds in raw counts
   assign eval_stb = (sense_r[5:4] == SRC_OVERSAMPLED) ? sample_os_stb : sample_odr_stb;
   assign mx       = mag(accel_x);
   assign my       = mag(accel_y);
   assign mz       = mag(accel_z);
   assign msum     = {2'h0, mx} + {2'h0, my} + {2'h0, mz};
   assign fs_sel   = (sense_r[1:0] > FS_8G) ? FS_8G : sense_r[1:0];
   assign fall_sh  = FALL_STEP_SHIFT_2G - {2'h0, fs_sel};
   assign hyst_sh  = HYST_STEP_SHIFT_2G - {2'h0, fs_sel};
   assign fall_th_lsb   = {8'h00, fall_th_r} << fall_sh;
   assign fall_exit_lsb = fall_th_lsb + ({14'h0000, fall_hyst_r[1:0]} << hyst_sh);
   assign mot_th_lsb    = {8'h00, mot_th_r} << MOT_STEP_SHIFT;
   assign knock_th_lsb  = {11'h000, knock_th_r[4:0]} << KNOCK_STEP_SHIFT;

   // Free fall
   always_comb begin
      if (fall_hyst_r[FALL_MODE_BIT]) begin
         fall_below = msum < fall_th_lsb;
         fall_exit  = msum > fall_exit_lsb;
      end else begin
         fall_below = ({2'h0, mx} < fall_th_lsb) && ({2'h0, my} < fall_th_lsb) && ({2'h0, mz} < fall_th_lsb);
         fall_exit  = ({2'h0, mx} > fall_exit_lsb) || ({2'h0, my} > fall_exit_lsb) || ({2'h0, mz} > fall_exit_lsb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fall_cond_r <= 1'b0;
      end else if (eval_stb) begin
         fall_cond_r <= fall_cond_r ? !fall_exit : fall_below;
      end
   end

   assign fall_target = 10'(({2'h0, fall_dly_r} + 10'h001) * FALL_STEP_MS);
   assign fall_evt    = fall_cond_r && !fall_fired_r && (fall_cnt_r == fall_target);

   always_ff @(posedge aclk) begin
      if (!aresetn || !fall_cond_r) begin
         fall_cnt_r   <= 10'h000;
         fall_fired_r <= 1'b0;
      end else if (fall_evt) begin
         fall_fired_r <= 1'b1;
      end else if (ms_tick && !fall_fired_r) begin
         fall_cnt_r <= fall_cnt_r + 10'h001;
      end
   end

   // Activity and inactivity over consecutive evaluation periods
   assign mot_over = ({2'h0, mx} > mot_th_lsb) || ({2'h0, my} > mot_th_lsb) || ({2'h0, mz} > mot_th_lsb);
   assign act_evt  = eval_stb && mot_over && !active_r && (act_cnt_r == {1'b0, mot_dur_r[3:0]});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_cnt_r   <= 5'h00;
         inact_cnt_r <= 5'h00;
         active_r    <= 1'b0;
      end else if (eval_stb) begin
         act_cnt_r   <= mot_over ? act_cnt_r + {4'h0, act_cnt_r != 5'h1F} : 5'h00;
         inact_cnt_r <= mot_over ? 5'h00 : inact_cnt_r + {4'h0, inact_cnt_r != 5'h1F};
         if (act_evt) begin
            active_r <= 1'b1;
         end else if (active_r && !mot_over && inact_cnt_r == {1'b0, mot_dur_r[7:4]}) begin
            active_r <= 1'b0;
         end
      end
   end

   // Knock detection: shock, quiet, then a window for a second shock
   assign knock_over = ({2'h0, mx} > knock_th_lsb) || ({2'h0, my} > knock_th_lsb) || ({2'h0, mz} > knock_th_lsb);
   assign shock_ms   = knock_time_r[KNOCK_SHOCK_BIT] ? SHOCK_MS_1 : SHOCK_MS_0;
   assign quiet_ms   = knock_time_r[KNOCK_QUIET_BIT] ? QUIET_MS_1 : QUIET_MS_0;
   assign window_ms  = WINDOW_MS[knock_time_r[2:0]];
   assign double_evt = (knock_state_r == KNOCK_WAIT2) && eval_stb && knock_over;
   // At or past the window end, so a shorter window written mid-wait still ends it
   assign single_evt = (knock_state_r == KNOCK_WAIT2) && !double_evt && ms_tick && (knock_ms_r >= window_ms - 10'h001);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         knock_state_r <= KNOCK_IDLE;
         knock_ms_r    <= 10'h000;
      end else begin
         unique case (knock_state_r)
            KNOCK_IDLE: begin
               knock_ms_r <= 10'h000;
               if (eval_stb && knock_over) begin
                  knock_state_r <= KNOCK_SHOCK;
               end
            end
            KNOCK_SHOCK, KNOCK_SHOCK2: begin
               if (ms_tick) begin
                  knock_ms_r <= (knock_ms_r >= shock_ms - 10'h001) ? 10'h000 : knock_ms_r + 10'h001;
                  if (knock_ms_r >= shock_ms - 10'h001) begin
                     knock_state_r <= (knock_state_r == KNOCK_SHOCK) ? KNOCK_QUIET : KNOCK_IDLE;
                  end
               end
            end
            KNOCK_QUIET: begin
               if (ms_tick) begin
                  knock_ms_r <= (knock_ms_r >= quiet_ms - 10'h001) ? 10'h000 : knock_ms_r + 10'h001;
                  if (knock_ms_r >= quiet_ms - 10'h001) begin
                     knock_state_r <= KNOCK_WAIT2;
                  end
               end
            end
            KNOCK_WAIT2: begin
               if (double_evt) begin
                  knock_state_r <= KNOCK_SHOCK2;
                  knock_ms_r    <= 10'h000;
               end else if (single_evt) begin
                  knock_state_r <= KNOCK_IDLE;
               end else if (ms_tick) begin
                  knock_ms_r <= knock_ms_r + 10'h001;
               end
            end
         endcase
      end
   end

   always_comb begin
      evt_vec             = 8'h00;
      evt_vec[EVT_SINGLE] = single_evt;
      evt_vec[EVT_DOUBLE] = double_evt;
      evt_vec[EVT_ACTIVE] = act_evt;
      evt_vec[EVT_FALL]   = fall_evt;
   end

   // Pin hold logic; a new routed event wins over a clear in the same cycle
   assign mapped_evt = |(evt_vec & route_r);
   assign hold_code  = hold_mode_r[3:0];
   assign hold_none  = (hold_code == HOLD_NONE_A) || (hold_code == HOLD_NONE_B);
   assign hold_latch = (hold_code == HOLD_LATCH_A) || (hold_code == HOLD_LATCH_B);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held_r     <= 1'b0;
         hold_cnt_r <= 14'h0000;
      end else if (mapped_evt) begin
         held_r     <= 1'b1;
         hold_cnt_r <= 14'h0000;
      end else if (clear_strobe || hold_none) begin
         held_r <= 1'b0;
      end else if (held_r && !hold_latch && ms_tick) begin
         hold_cnt_r <= hold_cnt_r + 14'h0001;
         if (hold_cnt_r == HOLD_MS[hold_code] - 14'h0001) begin
            held_r <= 1'b0;
         end
      end
   end

   // Open drain releases the wire for its high level, so the bus pull-up sets it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_pin_out  <= 1'b0;
         event_pin_oe_n <= 1'b0;
      end else begin
         event_pin_out  <= pin_od ? 1'b0 : (held_r ^ pin_pol);
         event_pin_oe_n <= pin_od ? (held_r ^ pin_pol) : 1'b0;
      end
   end

   sequence s_clear_req;
      clear_strobe && !mapped_evt;
   endsequence
   sequence s_hold_expire;
      held_r && !hold_none && !hold_latch && ms_tick && !mapped_evt && !clear_strobe &&
      (hold_cnt_r == HOLD_MS[hold_code] - 14'h0001);
   endsequence

   AST_CLEAR_RELEASES: assert property (s_clear_req |=> !held_r) else $error("clear did not release pin");
   AST_CLEAR_READS_ZERO: assert property (arready && arvalid && araddr[7:2] == IDX_PIN_CFG |=> rvalid && !rdata[CFG_CLEAR_BIT])
      else $error("clear bit read back as one");
   AST_PUSH_PULL: assert property (!pin_od |=> !event_pin_oe_n) else $error("push-pull pin not driven");
   AST_OPEN_DRAIN: assert property (pin_od && held_r && !pin_pol |=> event_pin_oe_n && !event_pin_out)
      else $error("open-drain high level not released");
   AST_ACTIVE_LOW: assert property (!pin_od && held_r && pin_pol |=> !event_pin_out) else $error("active-low pin high");
   AST_NO_HOLD: assert property (hold_none && !mapped_evt |=> !held_r) else $error("pin held in follow mode");
   AST_LATCH_STAYS: assert property (held_r && hold_latch && !clear_strobe |=> held_r) else $error("latched pin dropped");
   AST_TIMED_RELEASE: assert property (s_hold_expire |=> !held_r ##1 (event_pin_out == (pin_od ? 1'b0 : pin_pol)))
      else $error("timed hold did not release");
   AST_TIMED_KEEP: assert property (held_r && !hold_none && !hold_latch && !clear_strobe &&
      (hold_cnt_r < HOLD_MS[hold_code] - 14'h0001) |=> held_r) else $error("timed hold released early");
   AST_FALL_TIME: assert property (fall_evt |-> fall_cnt_r == {1'b0, fall_dly_r, 1'b0} + 10'h002 ##1 !fall_evt)
      else $error("free fall fired at wrong time");
   AST_ACT_COUNT: assert property (act_evt |-> act_cnt_r == {1'b0, mot_dur_r[3:0]} ##1 active_r)
      else $error("activity fired at wrong count");
   AST_STATUS_SET: assert property (evt_vec != 8'h00 |=> (status_r & $past(evt_vec)) == $past(evt_vec))
      else $error("event flag not set");
   AST_ROUTE: assert property ($rose(held_r) |-> $past(mapped_evt)) else $error("unrouted event drove pin");
   AST_DOUBLE_KNOCK: assert property (double_evt |=> knock_state_r == KNOCK_SHOCK2 && knock_ms_r == 10'h000)
      else $error("second knock not taken");
endmodule
`default_nettype wire

// *** mei_host_irq.sv ***
`timescale 1ns/1ns
`default_nettype none
module mei_host_irq (
   // Pin from the device
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   // Host side view
   input  wire logic active_low,
   output var  logic pin_level,
   output var  logic irq
);
   // Host board pull-up: a released pin reads high, never the last driven value
   assign pin_level = pin_oe_n ? 1'b1 : pin_out;
   assign irq       = pin_level ^ active_low;
endmodule
`default_nettype wire

// *** mei_top_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module mei_top_tb_top;
   import mei_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, os_stb = 1'b0, pol_low = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd_data;
   logic [13:0] accel_x = 14'h1000;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata;
   logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe_n, pin_level, irq;
   int          n_mismatch = 0, total_checks = 0, n, k;
   logic [5:0]  ridx [9] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h27, 6'h28, 6'h2A, 6'h2B};
   logic [7:0]  rval [9] = '{8'h00, 8'h00, 8'h09, 8'h30, 8'h01, 8'h00, 8'h14, 8'h04, 8'h0A};
   always #50 aclk = ~aclk;
   always @(posedge aclk) os_stb <= ~os_stb;
   mei_top #(.MS_CYCLES(10)) mei_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .accel_x(accel_x), .accel_y(14'h0000),
      .accel_z(14'h0000), .sample_os_stb(os_stb), .sample_odr_stb(1'b0), .event_pin_out(pin_out),
      .event_pin_oe_n(pin_oe_n));
   mei_host_irq mei_host_irq_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .active_low(pol_low),
      .pin_level(pin_level), .irq(irq));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic bound(input int i, input int lim = 400);
      if (i >= lim) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      int i;
      @(posedge aclk);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 400 && awready !== 1'b1; i++) @(posedge aclk);
      bound(i);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      for (i = 0; i < 400 && bvalid !== 1'b1; i++) @(posedge aclk);
      bound(i);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx);
      int i;
      @(posedge aclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 400 && arready !== 1'b1; i++) @(posedge aclk);
      bound(i);
      arvalid <= 1'b0;
      for (i = 0; i < 400 && rvalid !== 1'b1; i++) @(posedge aclk);
      bound(i);
      rd_data = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // A new free-fall episode needs an exit above threshold plus hysteresis first
   task automatic fall_wait();
      int i;
      accel_x <= 14'h1000;
      repeat (10) @(posedge aclk);
      accel_x <= 14'h0000;
      for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge aclk);
      bound(i);
   endtask
   // One evaluation above the knock level, then still
   task automatic knock();
      accel_x <= 14'h1000;
      repeat (2) @(posedge aclk);
      accel_x <= 14'h0000;
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < 9; k++) begin
         rd(ridx[k]);
         chk("reset value", rd_data, {24'h0, rval[k]});
      end
      rd(6'h3F);
      chk("unmapped read", {30'h0, resp}, 32'h2);
      wr(6'h3F, 8'h11);
      chk("unmapped write", {30'h0, resp}, 32'h2);
      wr(6'h23, 8'h5A);
      rd(6'h23);
      chk("threshold rw", rd_data, 32'h5A);
      wr(6'h20, 8'h80);
      rd(6'h20);
      chk("clear bit reads zero", rd_data, 32'h00);
      $display("test registers done");
      wr(6'h30, 8'h01);
      wr(6'h21, 8'h07);
      wr(6'h22, 8'h00);
      wr(6'h31, 8'hFF);
      fall_wait();
      chk("push-pull drive", {30'h0, pin_oe_n, pin_out}, 32'h1);
      repeat (100) @(posedge aclk);
      chk("latched pin", {31'h0, irq}, 32'h1);
      rd(6'h31);
      chk("fall status", rd_data & 32'h1, 32'h1);
      wr(6'h20, 8'h80);
      repeat (3) @(posedge aclk);
      chk("pin after clear", {31'h0, irq}, 32'h0);
      wr(6'h31, 8'h01);
      rd(6'h31);
      chk("status cleared", rd_data & 32'h1, 32'h0);
      $display("test latched done");
      wr(6'h20, 8'h03);
      pol_low <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("open drain idle", {30'h0, pin_oe_n, pin_level}, 32'h3);
      fall_wait();
      chk("open drain active", {30'h0, pin_oe_n, pin_out}, 32'h0);
      wr(6'h20, 8'h83);
      repeat (3) @(posedge aclk);
      chk("open drain after clear", {31'h0, irq}, 32'h0);
      $display("test open drain done");
      wr(6'h20, 8'h00);
      pol_low <= 1'b0;
      wr(6'h21, 8'h0C);
      fall_wait();
      for (n = 0; n < 400 && irq === 1'b1; n++) @(posedge aclk);
      chk("timed hold 25ms", {31'h0, n >= 240 && n <= 250}, 32'h1);
      $display("test timed hold done");
      wr(6'h2A, 8'h00);
      wr(6'h21, 8'h00);
      wr(6'h30, 8'h30);
      repeat (1400) @(posedge aclk);
      wr(6'h31, 8'hFF);
      knock();
      for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge aclk);
      bound(n, 2000);
      chk("single knock time", {31'h0, n >= 1290 && n <= 1305}, 32'h1);
      @(posedge aclk);
      chk("follow pulse", {31'h0, irq}, 32'h0);
      rd(6'h31);
      chk("knock status", rd_data & 32'h34, 32'h24);
      wr(6'h31, 8'hFF);
      knock();
      repeat (900) @(posedge aclk);
      knock();
      for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge aclk);
      bound(n);
      rd(6'h31);
      chk("double knock status", rd_data & 32'h30, 32'h10);
      $display("test knock done");
      accel_x <= 14'h1000;
      wr(6'h32, 8'h02);
      wr(6'h30, 8'h01);
      accel_x <= 14'h0400;
      repeat (100) @(posedge aclk);
      chk("no fall at 8g", {31'h0, irq}, 32'h0);
      wr(6'h32, 8'h00);
      for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge aclk);
      bound(n);
      chk("fall at 2g", {31'h0, irq}, 32'h1);
      $display("test full scale done");
      stop_test();
   end
endmodule
`default_nettype wire
